/* logic/iopm_regs.svh */
// Register offsets, field positions, reset values and pin maps of the I/O port mux
`ifndef IOPM_REGS_SVH
`define IOPM_REGS_SVH

// Register offsets in the special-function space
`define IOPM_OFF_PORT0_DATA    8'h80
`define IOPM_OFF_PORT1_DATA    8'h90
`define IOPM_OFF_PORT2_DATA    8'hA0
`define IOPM_OFF_LOC_SELECT    8'hF1
`define IOPM_OFF_ANALOG_EN     8'hF2
`define IOPM_OFF_PORT0_FSEL    8'hF3
`define IOPM_OFF_PORT1_FSEL    8'hF4
`define IOPM_OFF_PORT2_FPRI    8'hF5
`define IOPM_OFF_PORT0_DIR     8'hFD

// Reset values
`define IOPM_RST_PORT0_DATA    8'hFF
`define IOPM_RST_PORT1_DATA    8'hFF
`define IOPM_RST_PORT2_DATA    5'h1F
`define IOPM_RST_ZERO          8'h00

// Writable masks (unused bits stay zero)
`define IOPM_MASK_PORT2_DATA   8'h1F
`define IOPM_MASK_LOC_SELECT   8'h73
`define IOPM_MASK_PORT2_FPRI   8'h7F

// Field positions in the location select register
`define IOPM_LOC_TIMER_ONE     6
`define IOPM_LOC_TIMER_THREE   5
`define IOPM_LOC_TIMER_FOUR    4
`define IOPM_LOC_SERIAL_ONE    1
`define IOPM_LOC_SERIAL_ZERO   0

// Field positions in the port 2 function/priority register
`define IOPM_PRI_SERIAL_PAIR   6
`define IOPM_PRI_SER1_TMR3     5
`define IOPM_PRI_TMR1_TMR4     4
`define IOPM_PRI_SER0_TMR1     3
`define IOPM_SEL_P2_PIN4       2
`define IOPM_SEL_P2_PIN3       1
`define IOPM_SEL_P2_PIN0       0

// Flat pin index: port 0 at 0..7, port 1 at 8..15, port 2 at 16..20
`define IOPM_P1_BASE           8
`define IOPM_P2_BASE           16
`define IOPM_PIN_RADIO_BASE    12
`define IOPM_PIN_DBG_DATA      17
`define IOPM_PIN_DBG_CLOCK     18
`define IOPM_PIN_XOSC_Q1       19
`define IOPM_PIN_XOSC_Q2       20

// Pins claimed by each unit at each location, flat index
`define IOPM_MAP_SER0_ALT1     21'h00_003C
`define IOPM_MAP_SER0_ALT2     21'h00_3C00
`define IOPM_MAP_SER1_ALT1     21'h00_003C
`define IOPM_MAP_SER1_ALT2     21'h00_F000
`define IOPM_MAP_TMR1_ALT1     21'h00_001C
`define IOPM_MAP_TMR1_ALT2     21'h00_0700
`define IOPM_MAP_TMR3_ALT1     21'h00_1800
`define IOPM_MAP_TMR3_ALT2     21'h00_C000
`define IOPM_MAP_TMR4_ALT1     21'h00_0300
`define IOPM_MAP_TMR4_ALT2     21'h09_0000

`endif

/* logic/iopm_pkg.sv */
// Types shared by the I/O port mux modules
package iopm_pkg;

    // Number of pins over all three ports
    localparam int IOPM_PINS = 21;

    // Owner of a pin after location and priority resolution
    typedef enum logic [2:0] {
        IOPM_OWN_GPIO  = 3'b000,
        IOPM_OWN_SER0  = 3'b001,
        IOPM_OWN_SER1  = 3'b010,
        IOPM_OWN_TMR1  = 3'b011,
        IOPM_OWN_TMR3  = 3'b100,
        IOPM_OWN_TMR4  = 3'b101
    } iopm_owner_t;

    // Special-function register access from the core
    typedef struct packed {
        logic [7:0] addr;    // Register offset
        logic       wr;      // Byte write strobe
        logic       rd;      // Read strobe
        logic [7:0] wdata;   // Byte write data
        logic       bit_wr;  // Single-bit write strobe
        logic [2:0] bit_idx; // Bit number for a bit write
        logic       bit_val; // Bit value for a bit write
    } iopm_sfr_req_t;

    // One unit's drive onto the flat pin vector
    typedef struct packed {
        logic [20:0] out; // Output level per pin
        logic [20:0] oe;  // Output enable per pin
    } iopm_drive_t;

    // Radio status bits, fifo in bit 0 so pin P1.4+k takes bit k
    typedef struct packed {
        logic cca;   // Channel clear
        logic frame_delimiter_status;   // Frame delimiter
        logic fifo_threshold_status; // FIFO threshold
        logic fifo;  // FIFO not empty
    } iopm_radio_t;

endpackage

/* logic/iopm_pin_sync.sv */
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
module iopm_pin_sync #(
    parameter int W = 21
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    // Raw pins and filtered levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);
    import iopm_pkg::*;

    // Refuse a width the logic cannot serve
    if (W < 1) begin : g_chk
        $error("iopm_pin_sync: W must be at least 1");
    end

    // All flops of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1;     // First stage, read only by s2
        logic [W-1:0] s2;     // Second stage
        logic [W-1:0] s3;     // Third stage
        logic [W-1:0] stable; // Level accepted when s2 and s3 agree
    } iopm_sync_st_t;

    iopm_sync_st_t st;      // Current state
    iopm_sync_st_t next_st; // Next state

    // Shift and accept a bit once two late stages agree
    always_comb begin
        next_st        = st;
        next_st.s1     = async_i;
        next_st.s2     = st.s1;
        next_st.s3     = st.s2;
        next_st.stable = (st.s2 & ~(st.s2 ^ st.s3)) | (st.stable & (st.s2 ^ st.s3));
    end

    // Register the state; reset to all high like the pulled pins
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.stable;

endmodule

/* logic/iopm_pin_owner.sv */
// Resolves which peripheral owns each pin from locations and priorities
`timescale 1ns/1ps
`include "iopm_regs.svh"
module iopm_pin_owner (
    // Configuration
    input  wire logic [7:0]          loc_sel_i,
    input  wire logic [7:0]          fpri_i,
    // Owner of each flat pin
    output iopm_pkg::iopm_owner_t    owner_o [21]
);
    import iopm_pkg::*;

    logic [20:0] claim_ser0; // Pins wanted by serial unit zero
    logic [20:0] claim_ser1; // Pins wanted by serial unit one
    logic [20:0] claim_tmr1; // Pins wanted by timer one
    logic [20:0] claim_tmr3; // Pins wanted by timer three
    logic [20:0] claim_tmr4; // Pins wanted by timer four

    // Location bit picks alternative 1 or 2 map
    always_comb begin
        claim_ser0 = loc_sel_i[`IOPM_LOC_SERIAL_ZERO] ? `IOPM_MAP_SER0_ALT2
                                                      : `IOPM_MAP_SER0_ALT1;
        claim_ser1 = loc_sel_i[`IOPM_LOC_SERIAL_ONE] ? `IOPM_MAP_SER1_ALT2
                                                     : `IOPM_MAP_SER1_ALT1;
        claim_tmr1 = loc_sel_i[`IOPM_LOC_TIMER_ONE] ? `IOPM_MAP_TMR1_ALT2
                                                    : `IOPM_MAP_TMR1_ALT1;
        claim_tmr3 = loc_sel_i[`IOPM_LOC_TIMER_THREE] ? `IOPM_MAP_TMR3_ALT2
                                                      : `IOPM_MAP_TMR3_ALT1;
        claim_tmr4 = loc_sel_i[`IOPM_LOC_TIMER_FOUR] ? `IOPM_MAP_TMR4_ALT2
                                                     : `IOPM_MAP_TMR4_ALT1;
    end

    // Drop the loser of each documented pair, then take the first left
    always_comb begin
        logic [4:0] c; // Claims: 0 ser0, 1 ser1, 2 tmr1, 3 tmr3, 4 tmr4
        c = '0;
        for (int i = 0; i < 21; i++) begin
            c = {claim_tmr4[i], claim_tmr3[i], claim_tmr1[i], claim_ser1[i], claim_ser0[i]};
            // Only port 1 has the priority controls
            if (i >= `IOPM_P1_BASE && i < `IOPM_P2_BASE) begin
                if (c[0] && c[1]) begin
                    if (fpri_i[`IOPM_PRI_SERIAL_PAIR]) c[0] = 1'b0; else c[1] = 1'b0;
                end
                if (c[1] && c[3]) begin
                    if (fpri_i[`IOPM_PRI_SER1_TMR3]) c[1] = 1'b0; else c[3] = 1'b0;
                end
                if (c[2] && c[4]) begin
                    if (fpri_i[`IOPM_PRI_TMR1_TMR4]) c[2] = 1'b0; else c[4] = 1'b0;
                end
                if (c[0] && c[2]) begin
                    if (fpri_i[`IOPM_PRI_SER0_TMR1]) c[0] = 1'b0; else c[2] = 1'b0;
                end
            end
            // Unlisted overlaps fall to a fixed order
            if (c[0])      owner_o[i] = IOPM_OWN_SER0;
            else if (c[1]) owner_o[i] = IOPM_OWN_SER1;
            else if (c[2]) owner_o[i] = IOPM_OWN_TMR1;
            else if (c[3]) owner_o[i] = IOPM_OWN_TMR3;
            else if (c[4]) owner_o[i] = IOPM_OWN_TMR4;
            else           owner_o[i] = IOPM_OWN_GPIO;
        end
    end

endmodule

/* logic/iopm_top.sv */
// I/O port data latches, configuration registers and pin multiplexer
`timescale 1ns/1ps
`include "iopm_regs.svh"
module iopm_top (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    // Special-function register port
    input  wire iopm_pkg::iopm_sfr_req_t sfr_i,
    output logic [7:0]                 sfr_rdata_o,
    // Peripheral unit drives: 0 ser0, 1 ser1, 2 tmr1, 3 tmr3, 4 tmr4
    input  wire iopm_pkg::iopm_drive_t unit_drive_i [5],
    // Direction of ports 1 and 2 from the neighbouring direction registers
    input  wire logic [7:0]            port1_dir_i,
    input  wire logic [4:0]            port2_dir_i,
    // Crystal oscillator source select, low claims P2.3 and P2.4
    input  wire logic                  low_freq_osc_source_select_i,
    // Radio test output
    input  wire logic [3:0]            radio_test_en_i,
    input  wire iopm_pkg::iopm_radio_t radio_status_bits_i,
    // Debug interface
    input  wire logic                  dbg_active_i,
    input  wire logic                  dbg_data_out_i,
    input  wire logic                  dbg_data_oe_i,
    // Package pins, flat index
    input  wire logic [20:0]           pin_i,
    output logic [20:0]                pin_o,
    output logic [20:0]                pin_oe_o,
    output logic [20:0]                pin_analog_o,
    // Synchronised pin levels and ownership to the units
    output logic [20:0]                pin_level_o,
    output logic [20:0]                pin_periph_o
);
    import iopm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    // Every flop of the block except those of the input synchroniser
    typedef struct packed {
        logic [7:0]  port0_data;                  // Port 0 latch
        logic [7:0]  port1_data;                  // Port 1 latch
        logic [4:0]  port2_data;                  // Port 2 latch
        logic [7:0]  peripheral_location_select;  // Unit locations
        logic [7:0]  analog_input_enable;         // Port 0 analog enables
        logic [7:0]  port0_function_select;       // Port 0 function select
        logic [7:0]  port1_function_select;       // Port 1 function select
        logic [7:0]  port2_function_priority;     // Port 2 select and priorities
        logic [7:0]  port0_direction;             // Port 0 direction
        logic [7:0]  rdata;                       // Read data holding register
        logic [20:0] pin_out;                     // Registered pin level
        logic [20:0] pin_oe;                      // Registered pin enable
        logic [20:0] pin_analog;                  // Registered analog mode
        logic [20:0] pin_periph;                  // Registered peripheral grant
    } iopm_state_t;

    iopm_state_t st;      // Current state
    iopm_state_t next_st; // Next state

    logic [20:0]  level;       // Filtered pin levels
    iopm_owner_t  owner [21];  // Resolved owner per pin
    logic [20:0]  fsel;        // Function select, flat
    logic [20:0]  gpio_dir;    // GPIO direction, flat
    logic [20:0]  gpio_data;   // GPIO latch, flat
    logic [7:0]   rd_val;      // Read value of the addressed register

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Pins cross from outside, so filter them first
    iopm_pin_sync #(
        .W       (21)
    ) u_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .async_i (pin_i),
        .level_o (level)
    );

    // Location and priority resolution
    iopm_pin_owner u_owner (
        .loc_sel_i (st.peripheral_location_select),
        .fpri_i    (st.port2_function_priority),
        .owner_o   (owner)
    );

    // Flatten per-port controls onto the pin index
    always_comb begin
        fsel = {st.port2_function_priority[`IOPM_SEL_P2_PIN4],
                st.port2_function_priority[`IOPM_SEL_P2_PIN3],
                2'b00,
                st.port2_function_priority[`IOPM_SEL_P2_PIN0],
                st.port1_function_select,
                st.port0_function_select};
        gpio_dir  = {port2_dir_i, port1_dir_i, st.port0_direction};
        gpio_data = {st.port2_data, st.port1_data, st.port0_data};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read

    // Data registers read the pin for inputs and the latch for outputs
    always_comb begin
        case (sfr_i.addr)
            `IOPM_OFF_PORT0_DATA: begin
                rd_val = (st.port0_data & st.pin_oe[7:0])
                       | (level[7:0] & ~st.pin_oe[7:0]);
            end
            `IOPM_OFF_PORT1_DATA: begin
                rd_val = (st.port1_data & st.pin_oe[15:8])
                       | (level[15:8] & ~st.pin_oe[15:8]);
            end
            `IOPM_OFF_PORT2_DATA: begin
                rd_val = {3'b000, (st.port2_data & st.pin_oe[20:16])
                                | (level[20:16] & ~st.pin_oe[20:16])};
            end
            `IOPM_OFF_LOC_SELECT: rd_val = st.peripheral_location_select;
            `IOPM_OFF_ANALOG_EN:  rd_val = st.analog_input_enable;
            `IOPM_OFF_PORT0_FSEL: rd_val = st.port0_function_select;
            `IOPM_OFF_PORT1_FSEL: rd_val = st.port1_function_select;
            `IOPM_OFF_PORT2_FPRI: rd_val = st.port2_function_priority;
            `IOPM_OFF_PORT0_DIR:  rd_val = st.port0_direction;
            // Unmapped offsets answer zero
            default:              rd_val = `IOPM_RST_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Register writes, then the pin multiplexer
    always_comb begin
        logic [7:0] w; // Byte write data; bit writes bypass it
        w       = '0;
        next_st = st;

        // Read data is captured on the read strobe and held
        if (sfr_i.rd) begin
            next_st.rdata = rd_val;
        end

        // Bit writes touch one latch bit, byte writes the whole register
        if (sfr_i.bit_wr) begin
            case (sfr_i.addr)
                `IOPM_OFF_PORT0_DATA: begin
                    next_st.port0_data[sfr_i.bit_idx] = sfr_i.bit_val;
                end
                `IOPM_OFF_PORT1_DATA: begin
                    next_st.port1_data[sfr_i.bit_idx] = sfr_i.bit_val;
                end
                `IOPM_OFF_PORT2_DATA: begin
                    // Bits above 4 do not exist and are dropped
                    if (sfr_i.bit_idx < 3'd5) begin
                        next_st.port2_data[sfr_i.bit_idx] = sfr_i.bit_val;
                    end
                end
                default: begin
                    w = '0;
                end
            endcase
        end else if (sfr_i.wr) begin
            w = sfr_i.wdata;
            case (sfr_i.addr)
                `IOPM_OFF_PORT0_DATA: next_st.port0_data = w;
                `IOPM_OFF_PORT1_DATA: next_st.port1_data = w;
                `IOPM_OFF_PORT2_DATA: next_st.port2_data = w[4:0];
                `IOPM_OFF_LOC_SELECT: begin
                    next_st.peripheral_location_select = w & `IOPM_MASK_LOC_SELECT;
                end
                `IOPM_OFF_ANALOG_EN:  next_st.analog_input_enable = w;
                `IOPM_OFF_PORT0_FSEL: next_st.port0_function_select = w;
                `IOPM_OFF_PORT1_FSEL: next_st.port1_function_select = w;
                `IOPM_OFF_PORT2_FPRI: begin
                    next_st.port2_function_priority = w & `IOPM_MASK_PORT2_FPRI;
                end
                `IOPM_OFF_PORT0_DIR:  next_st.port0_direction = w;
                // Unmapped writes are ignored
                default: begin
                    w = '0;
                end
            endcase
        end

        // Pin multiplexer, lowest priority first, later overrides win
        for (int i = 0; i < 21; i++) begin
            // General-purpose I/O
            next_st.pin_out[i]    = gpio_data[i];
            next_st.pin_oe[i]     = gpio_dir[i];
            next_st.pin_analog[i] = 1'b0;
            next_st.pin_periph[i] = 1'b0;
            // Peripheral function when selected and a unit owns the pin
            if (fsel[i] && owner[i] != IOPM_OWN_GPIO) begin
                next_st.pin_out[i]    = unit_drive_i[int'(owner[i]) - 1].out[i];
                next_st.pin_oe[i]     = unit_drive_i[int'(owner[i]) - 1].oe[i];
                next_st.pin_periph[i] = 1'b1;
            end
            // Analog input beats the function select on port 0
            if (i < `IOPM_P1_BASE && st.analog_input_enable[i]) begin
                next_st.pin_oe[i]     = 1'b0;
                next_st.pin_out[i]    = 1'b0;
                next_st.pin_analog[i] = 1'b1;
                next_st.pin_periph[i] = 1'b0;
            end
        end

        // Debug interface owns its two pins; data may turn around
        if (dbg_active_i) begin
            next_st.pin_out[`IOPM_PIN_DBG_DATA]    = dbg_data_out_i;
            next_st.pin_oe[`IOPM_PIN_DBG_DATA]     = dbg_data_oe_i;
            next_st.pin_out[`IOPM_PIN_DBG_CLOCK]   = 1'b0;
            next_st.pin_oe[`IOPM_PIN_DBG_CLOCK]    = 1'b0;
        end

        // Crystal claims its pins whatever the registers say
        if (!low_freq_osc_source_select_i) begin
            next_st.pin_out[`IOPM_PIN_XOSC_Q1]    = 1'b0;
            next_st.pin_oe[`IOPM_PIN_XOSC_Q1]     = 1'b0;
            next_st.pin_analog[`IOPM_PIN_XOSC_Q1] = 1'b1;
            next_st.pin_periph[`IOPM_PIN_XOSC_Q1] = 1'b0;
            next_st.pin_out[`IOPM_PIN_XOSC_Q2]    = 1'b0;
            next_st.pin_oe[`IOPM_PIN_XOSC_Q2]     = 1'b0;
            next_st.pin_analog[`IOPM_PIN_XOSC_Q2] = 1'b1;
            next_st.pin_periph[`IOPM_PIN_XOSC_Q2] = 1'b0;
        end

        // Radio test outputs sit on top of everything on P1.7..P1.4
        for (int k = 0; k < 4; k++) begin
            if (radio_test_en_i[k]) begin
                next_st.pin_out[`IOPM_PIN_RADIO_BASE + k]    = radio_status_bits_i[k];
                next_st.pin_oe[`IOPM_PIN_RADIO_BASE + k]     = 1'b1;
                next_st.pin_analog[`IOPM_PIN_RADIO_BASE + k] = 1'b0;
                next_st.pin_periph[`IOPM_PIN_RADIO_BASE + k] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Synchronous reset to the documented values; pins come up as inputs
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st                            <= '0;
            st.port0_data                 <= `IOPM_RST_PORT0_DATA;
            st.port1_data                 <= `IOPM_RST_PORT1_DATA;
            st.port2_data                 <= `IOPM_RST_PORT2_DATA;
            st.peripheral_location_select <= `IOPM_RST_ZERO;
            st.analog_input_enable        <= `IOPM_RST_ZERO;
            st.port0_direction            <= `IOPM_RST_ZERO;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops

    assign sfr_rdata_o  = st.rdata;
    assign pin_o        = st.pin_out;
    assign pin_oe_o     = st.pin_oe;
    assign pin_analog_o = st.pin_analog;
    assign pin_level_o  = level;
    assign pin_periph_o = st.pin_periph;

endmodule

/* sim/iopm_top_sva.sv */
// Port-level checker of the I/O port mux
`timescale 1ns/1ps
module iopm_top_sva (
    // Clock, reset and register port
    input wire logic [0:0]              clk_i,
    input wire logic [0:0]              srst_i,
    input wire iopm_pkg::iopm_sfr_req_t sfr_i,
    input wire logic [7:0]              sfr_rdata_o,
    // Overrides and pins
    input wire logic [0:0]              low_freq_osc_source_select_i,
    input wire logic [3:0]              radio_test_en_i,
    input wire iopm_pkg::iopm_radio_t   radio_status_bits_i,
    input wire logic [20:0]             pin_o,
    input wire logic [20:0]             pin_oe_o,
    input wire logic [20:0]             pin_analog_o
);
    import iopm_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Test output beats peripheral and GPIO drive on P1.7..P1.4
    property p_radio; radio_test_en_i == 4'hF |=> pin_oe_o[15:12] == 4'hF
        && pin_o[15:12] == $past(radio_status_bits_i); endproperty
    a_radio: assert property (p_radio) else $error("radio test pins wrong");
    property p_xosc; !low_freq_osc_source_select_i |=> pin_analog_o[20:19] == 2'b11
        && pin_oe_o[20:19] == 2'b00; endproperty
    a_xosc: assert property (p_xosc) else $error("crystal pins not analog");
    property p_unmap; sfr_i.rd && sfr_i.addr == 8'h00 |=> sfr_rdata_o == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_p2d; sfr_i.rd && sfr_i.addr == 8'hA0 |=> sfr_rdata_o[7:5] == 3'b000; endproperty
    a_p2d: assert property (p_p2d) else $error("port 2 high bits set");
    property p_loc; sfr_i.rd && sfr_i.addr == 8'hF1 |=> (sfr_rdata_o & 8'h8C) == 8'h00; endproperty
    a_loc: assert property (p_loc) else $error("location spare bits set");
    property p_fpri; sfr_i.rd && sfr_i.addr == 8'hF5 |=> !sfr_rdata_o[7]; endproperty
    a_fpri: assert property (p_fpri) else $error("priority bit 7 set");
    // Read data only moves on a read
    property p_hold; !sfr_i.rd |=> $stable(sfr_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_wrrd; sfr_i.wr && !sfr_i.bit_wr && sfr_i.addr inside {8'hF2, 8'hF3, 8'hF4, 8'hFD}
        ##1 !sfr_i.wr ##1 sfr_i.rd && sfr_i.addr == $past(sfr_i.addr, 2)
        |=> sfr_rdata_o == $past(sfr_i.wdata, 3); endproperty
    a_wrrd: assert property (p_wrrd) else $error("readback differs");
endmodule
bind iopm_top iopm_top_sva u_iopm_top_sva (.clk_i(clk_i), .srst_i(srst_i), .sfr_i(sfr_i),
    .sfr_rdata_o(sfr_rdata_o), .low_freq_osc_source_select_i(low_freq_osc_source_select_i),
    .radio_test_en_i(radio_test_en_i), .radio_status_bits_i(radio_status_bits_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_analog_o(pin_analog_o));

/* sim/iopm_pin_board.sv */
// Board side of the pins: bench drivers and pull-ups
`timescale 1ns/1ps
module iopm_pin_board (
    // Device drive
    input  wire logic [20:0] pin_o,
    input  wire logic [20:0] pin_oe_o,
    // Bench drive
    input  wire logic [20:0] ext_val_i,
    input  wire logic [20:0] ext_oe_i,
    // Resolved level back to the device
    output logic [20:0]      pin_i
);
    // Undriven pins float high through pull-ups, never to a stale value
    assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ~ext_oe_i) | (~pin_oe_o & ext_oe_i & ext_val_i);
endmodule

/* sim/iopm_top_test.sv */
// Self-checking bench of the I/O port mux
`timescale 1ns/1ps
module iopm_top_test;
    import iopm_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    iopm_sfr_req_t sfr = '0;
    // Unit drive levels differ inside every contested pair
    iopm_drive_t drv [5] = '{'{21'h0, '1}, '{'1, '1}, '{'1, '1}, '{21'h0, '1}, '{21'h0, '1}};
    logic [4:0] p2dir = 5'h00;
    logic osc = 1'b1;
    logic [3:0] rten = 4'h0;
    iopm_radio_t rbits = 4'h0;
    logic [2:0] dbg = 3'b000;
    logic [20:0] ext_v = '0, ext_e = '0, pin_i, pin_o, pin_oe, pin_an, pin_per, pin_lv;
    logic [7:0] rdata;
    int err_count = 0, n_tests = 0, cyc = 0;
    iopm_top u_iopm_top (.clk_i(clk_i), .srst_i(srst_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
        .unit_drive_i(drv), .port1_dir_i(8'h00), .port2_dir_i(p2dir),
        .low_freq_osc_source_select_i(osc), .radio_test_en_i(rten), .radio_status_bits_i(rbits),
        .dbg_active_i(dbg[2]), .dbg_data_out_i(dbg[1]), .dbg_data_oe_i(dbg[0]), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe), .pin_analog_o(pin_an), .pin_level_o(pin_lv),
        .pin_periph_o(pin_per));
    iopm_pin_board u_iopm_pin_board (.pin_o(pin_o), .pin_oe_o(pin_oe), .ext_val_i(ext_v),
        .ext_oe_i(ext_e), .pin_i(pin_i));
    always #2 clk_i = ~clk_i;
    // Hang guard, far above the hundred and sixty or so cycles used
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(string what, logic [20:0] exp, logic [20:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d, logic b = 1'b0, logic [2:0] i = 3'd0);
        @(posedge clk_i);
        sfr <= '{addr: a, wr: !b, wdata: d, bit_wr: b, bit_idx: i, bit_val: d[0], default: '0};
        @(posedge clk_i);
        sfr <= '0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk_i);
        sfr <= '{addr: a, rd: 1'b1, default: '0};
        @(posedge clk_i);
        sfr <= '0;
        #1;
        chk($sformatf("reg %h", a), 21'(exp), 21'(rdata));
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic t_regs();
        logic [7:0] a [10] = '{8'h80, 8'h90, 8'hA0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hFD, 8'h00};
        logic [7:0] e [10] = '{8'hFF, 8'hFF, 8'h1F, '0, '0, '0, '0, '0, '0, '0};
        logic [7:0] m [10] = '{8'hFF, 8'hFF, 8'h1F, 8'h73, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, '0};
        foreach (a[k]) rd(a[k], e[k]);
        for (int k = 3; k < 10; k++) begin
            wr(a[k], 8'hFF);
            rd(a[k], m[k]);
            wr(a[k], 8'h00);
        end
        $display("test regs done");
    endtask
    task automatic t_port0();
        wr(8'hFD, 8'hFF);
        wr(8'h80, 8'hA5);
        wr(8'h80, 8'h00, 1'b1, 3'd0);
        settle(2);
        chk("p0 drive", 21'h0_FFA4, {pin_oe[7:0], pin_o[7:0]});
        wr(8'hF2, 8'h08);
        wr(8'hF3, 8'h3C);
        settle(2);
        chk("p0 analog", 21'h0_0880, {pin_an[7:0], pin_o[7:0]});
        wr(8'hF2, 8'h00);
        wr(8'hF3, 8'h00);
        wr(8'hFD, 8'h00);
        @(posedge clk_i);
        ext_e <= 21'h0_00FF;
        ext_v <= 21'h0_003C;
        settle(6);
        chk("pin level", 21'h1F_FF3C, pin_lv);
        rd(8'h80, 8'h3C);
        @(posedge clk_i);
        ext_e <= '0;
        $display("test port0 done");
    endtask
    task automatic t_prio();
        logic [7:0] loc [4] = '{8'h03, 8'h22, 8'h40, 8'h41};
        logic [7:0] pri [4] = '{8'h40, 8'h20, 8'h10, 8'h08};
        int idx [4] = '{13, 14, 8, 10};
        logic e0 [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        wr(8'hF4, 8'hFF);
        foreach (loc[k]) begin
            wr(8'hF1, loc[k]);
            wr(8'hF5, 8'h00);
            settle(2);
            chk("prio low", 21'(e0[k]), 21'(pin_o[idx[k]]));
            wr(8'hF5, pri[k]);
            settle(2);
            chk("prio high", 21'(!e0[k]), 21'(pin_o[idx[k]] & pin_per[idx[k]]));
        end
        wr(8'hF5, 8'h00);
        $display("test prio done");
    endtask
    task automatic t_radio();
        @(posedge clk_i);
        rbits <= 4'hA;
        rten <= 4'hF;
        settle(2);
        chk("radio A", 21'h0_FA, {pin_oe[15:12], pin_o[15:12]});
        @(posedge clk_i);
        rbits <= 4'h5;
        settle(2);
        chk("radio 5", 21'h0_F5, {pin_oe[15:12], pin_o[15:12]});
        @(posedge clk_i);
        rten <= 4'h0;
        wr(8'hF4, 8'h00);
        $display("test radio done");
    endtask
    task automatic t_p2();
        p2dir <= 5'h1F;
        wr(8'hF5, 8'h06);
        wr(8'hA0, 8'hFF);
        wr(8'hA0, 8'h00, 1'b1, 3'd1);
        @(posedge clk_i);
        osc <= 1'b0;
        settle(2);
        chk("crystal", 21'h0_0C, {pin_an[20:19], pin_oe[20:19]});
        rd(8'hA0, 8'h1D);
        @(posedge clk_i);
        dbg <= 3'b111;
        settle(2);
        chk("debug", 21'h3, {pin_oe[18:17], pin_o[17]});
        $display("test port2 done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        t_regs();
        t_port0();
        t_prio();
        t_radio();
        t_p2();
        end_sim();
    end
endmodule
